//--- eeprom_cmd_regs.vh
// register map, field positions and constants of the eeprom command unit
`ifndef EEPROM_CMD_REGS_VH
`define EEPROM_CMD_REGS_VH
`define ADDR_FLASH_CONFIG   4'h0
`define ADDR_FLASH_STATUS   4'h1
`define ADDR_ECC_CONFIG     4'h2
`define ADDR_ECC_STATUS     4'h3
`define ADDR_EEPROM_PROT    4'h4
`define ADDR_PARAM_INDEX    4'h5
`define ADDR_PARAM_HI       4'h6
`define ADDR_PARAM_LO       4'h7
`define BIT_CC_IRQ_EN       7
`define BIT_CC_FLAG         7
`define BIT_ACC_ERR         5
`define BIT_PROT_VIOL       4
`define BIT_VERIFY_ERR      1
`define BIT_VERIFY_UNCORR   0
`define BIT_DF_BIT          1
`define BIT_SF_BIT          0
`define BIT_PROT_EN         7
`define PROT_FAULT_VALUE    8'h7F
`define PROT_RESET_VALUE    8'h7F
`define PARAM_WORDS         6
`define IDX_CMD_WORD        3'h0
`define IDX_ADDR_WORD       3'h1
`define CMD_SECTOR_ERASE    8'h12
`define CMD_BLOCK_ERASE     8'h10
`define EE_BASE             18'h00400
`define EE_END              18'h013FF
`define SECTOR_LOG2         2
`endif

//--- param_word_store.v
// six-word command parameter store with byte writes and registered read
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_cmd_regs.vh"
module param_word_store (
   input  wire        clk_sys,
   input  wire        srst,
   input  wire [2:0]  wrIndex,
   input  wire        wrHi,
   input  wire        wrLo,
   input  wire [7:0]  wrData,
   input  wire [2:0]  rdIndex,
   output reg  [15:0] rdData,
   output wire [15:0] cmdWord,
   output wire [15:0] addrWord
);
   reg [15:0] word_q [0:`PARAM_WORDS-1];
   genvar g;
   generate
      for (g = 0; g < `PARAM_WORDS; g = g + 1) begin : gWord
         always @(posedge clk_sys) begin
            if (srst) begin
               word_q[g] <= 16'h0000;
            end else if (wrIndex == g[2:0]) begin
               // indices 6 and 7 match no word, so their writes fall away
               if (wrHi) begin
                  word_q[g][15:8] <= wrData;
               end
               if (wrLo) begin
                  word_q[g][7:0] <= wrData;
               end
            end
         end
      end
   endgenerate
   always @(posedge clk_sys) begin
      if (srst) begin
         rdData <= 16'h0000;
      end else if (rdIndex < `PARAM_WORDS) begin
         rdData <= word_q[rdIndex];
      end else begin
         rdData <= 16'h0000;
      end
   end
   assign cmdWord  = word_q[`IDX_CMD_WORD];
   assign addrWord = word_q[`IDX_ADDR_WORD];
endmodule
`default_nettype wire

//--- eeprom_protect_range.v
// protection range decode for an eeprom address
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_cmd_regs.vh"
module eeprom_protect_range (
   input  wire [7:0]  protReg,
   input  wire [17:0] addr,
   output wire        sectorHit,
   output wire        anyProtected
);
   wire        protEnable;
   wire [17:0] topAddr;
   wire [17:0] sectorBase;
   assign protEnable   = protReg[`BIT_PROT_EN];
   // range grows in 32-byte steps from the eeprom base
   assign topAddr      = `EE_BASE + {6'h00, protReg[6:0], 5'h1F};
   assign sectorBase   = {addr[17:`SECTOR_LOG2], {`SECTOR_LOG2{1'b0}}};
   assign sectorHit    = protEnable && (sectorBase >= `EE_BASE) && (sectorBase <= topAddr);
   // even size zero covers a sector, so any enabled range blocks a block erase
   assign anyProtected = protEnable;
endmodule
`default_nettype wire

//--- eeprom_command_protection_unit.v
// command launch, protection and status front end of the eeprom controller
//
// Behaviour
// - double fault on protection byte fetch at reset clears enable, sets all size bits.
// - erase into protected eeprom is refused and sets protection violation.
// - whole-block eeprom erase refused when any sector is protected.
// - protection register bit 7 selects range protection or no protection.
// - size field protects from base upward in 32-byte steps, zero up to 0x041F.
// - six 16-bit parameter words chosen by a 3-bit index, byte-wide access.
// - software loads parameters, then writes 1 to completion flag to clear it and launch.
// - parameter writes blocked while completion flag is low; set again at completion.
// - indices 6 and 7 ignore writes and read as zero.
// - word 0 holds command and address 17:16, word 1 address 15:0.
// - sector erase uses command 0x12 with word 1 pointing into the sector.
// - sector erase erases, then verifies blank, then sets completion flag.
// - access error at launch if index is not 1 (0 for block erase) or mode forbids the command.
// - access error for a sector erase address outside the eeprom or an odd address.
// - verify error sets first verify bit, uncorrectable error also the second.
// - completion interrupt from flag, local enable and global processor mask.
// - separate double and single ecc fault flags, each with enable and mask.
// - completion flag held low through reset initialisation, then set.
// - reset aborts a running command at once.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_cmd_regs.vh"
module eeprom_command_protection_unit (
   input  wire        clk_sys,
   input  wire        srst,
   input  wire [3:0]  regAddr,
   input  wire [7:0]  regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output wire [7:0]  regRdData,
   input  wire [7:0]  initProtByte,
   input  wire        initProtValid,
   input  wire        initDoubleFault,
   input  wire        cmdModeAllowed,
   input  wire        eccSingleFault,
   input  wire        eccDoubleFault,
   input  wire        cpuIrqMask,
   output reg         eraseReq,
   output reg         eraseBlock,
   output reg  [17:0] eraseAddr,
   input  wire        eraseDone,
   output reg         verifyReq,
   input  wire        verifyDone,
   input  wire        verifyError,
   input  wire        verifyUncorrectable,
   output wire        irqCmdComplete,
   output wire        irqDoubleFault,
   output wire        irqSingleFault
);
   localparam [2:0] ST_INIT   = 3'h0;
   localparam [2:0] ST_IDLE   = 3'h1;
   localparam [2:0] ST_CHECK  = 3'h2;
   localparam [2:0] ST_ERASE  = 3'h3;
   localparam [2:0] ST_VERIFY = 3'h4;

   function wrHit;
      input [3:0] a;
      input [3:0] target;
      input       strobe;
      begin
         wrHit = strobe && (a == target);
      end
   endfunction

   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg         ccFlag_q;
   reg         access_error_flag_q;
   reg         protViol_q;
   reg         verErr_q;
   reg         verUncorr_q;
   reg         ccIrqEn_q;
   reg         dfIrqEn_q;
   reg         sfIrqEn_q;
   reg         dfFlag_q;
   reg         sfFlag_q;
   reg  [7:0]  protReg_q;
   reg  [2:0]  paramIdx_q;
   reg  [2:0]  launchIdx_q;
   reg  [7:0]  rdOther_q;
   reg  [1:0]  rdSel_q;
   wire [15:0] memRdData;
   wire [15:0] cmdWord;
   wire [15:0] addrWord;
   wire [17:0] cmdAddr;
   wire        sectorHit;
   wire        anyProtected;
   wire        launch;
   wire        paramWrOk;
   wire        isSectorErase;
   wire        isBlockErase;
   wire        addrBad;
   wire        accCheck;
   wire        protCheck;
   wire        checkFail;
   reg  [7:0]  rdMux;

   assign cmdAddr = {cmdWord[1:0], addrWord};
   // launch only when idle and no access error or protection violation is still standing
   assign launch = wrHit(regAddr, `ADDR_FLASH_STATUS, regWr) && regWrData[`BIT_CC_FLAG]
                   && ccFlag_q && !access_error_flag_q && !protViol_q && (state_q == ST_IDLE);
   assign paramWrOk = ccFlag_q;

   param_word_store uStore (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .wrIndex  (paramIdx_q),
      .wrHi     (wrHit(regAddr, `ADDR_PARAM_HI, regWr) && paramWrOk),
      .wrLo     (wrHit(regAddr, `ADDR_PARAM_LO, regWr) && paramWrOk),
      .wrData   (regWrData),
      .rdIndex  (paramIdx_q),
      .rdData   (memRdData),
      .cmdWord  (cmdWord),
      .addrWord (addrWord)
   );

   eeprom_protect_range uProt (
      .protReg      (protReg_q),
      .addr         (cmdAddr),
      .sectorHit    (sectorHit),
      .anyProtected (anyProtected)
   );

   assign isSectorErase = (cmdWord[15:8] == `CMD_SECTOR_ERASE);
   assign isBlockErase  = (cmdWord[15:8] == `CMD_BLOCK_ERASE);
   assign addrBad = (cmdAddr < `EE_BASE) || (cmdAddr > `EE_END) || cmdAddr[0];
   assign accCheck = isSectorErase ? ((launchIdx_q != `IDX_ADDR_WORD)
                                      || !cmdModeAllowed || addrBad)
                   : isBlockErase ? ((launchIdx_q != `IDX_CMD_WORD) || !cmdModeAllowed)
                   : 1'b1;
   // access errors take precedence, so an odd address never reports a violation
   assign protCheck = isSectorErase ? sectorHit : anyProtected;
   assign checkFail = accCheck || protCheck;

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_INIT: begin
            if (initProtValid) begin
               state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (launch) begin
               state_d = ST_CHECK;
            end
         end
         ST_CHECK: begin
            state_d = checkFail ? ST_IDLE : ST_ERASE;
         end
         ST_ERASE: begin
            if (eraseDone) begin
               state_d = ST_VERIFY;
            end
         end
         ST_VERIFY: begin
            if (verifyDone) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_INIT;
         end
      endcase
   end

   // synchronous reset drops any command in flight straight back to init
   always @(posedge clk_sys) begin
      if (srst) begin
         state_q <= ST_INIT;
      end else begin
         state_q <= state_d;
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         ccFlag_q <= 1'b0;
      end else if (state_q == ST_INIT) begin
         ccFlag_q <= initProtValid;
      end else if (launch) begin
         ccFlag_q <= 1'b0;
      end else if ((state_q == ST_CHECK && checkFail)
                   || (state_q == ST_VERIFY && verifyDone)) begin
         ccFlag_q <= 1'b1;
      end
   end

   // hardware sets win over a write-one-to-clear in the same cycle
   always @(posedge clk_sys) begin
      if (srst) begin
         access_error_flag_q   <= 1'b0;
         protViol_q <= 1'b0;
      end else begin
         if (state_q == ST_CHECK && accCheck) begin
            access_error_flag_q <= 1'b1;
         end else if (wrHit(regAddr, `ADDR_FLASH_STATUS, regWr)
                      && regWrData[`BIT_ACC_ERR]) begin
            access_error_flag_q <= 1'b0;
         end
         if (state_q == ST_CHECK && !accCheck && protCheck) begin
            protViol_q <= 1'b1;
         end else if (wrHit(regAddr, `ADDR_FLASH_STATUS, regWr)
                      && regWrData[`BIT_PROT_VIOL]) begin
            protViol_q <= 1'b0;
         end
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         verErr_q    <= 1'b0;
         verUncorr_q <= 1'b0;
      end else if (state_q == ST_INIT && initProtValid && initDoubleFault) begin
         verErr_q    <= 1'b1;
         verUncorr_q <= 1'b1;
      end else if (launch) begin
         verErr_q    <= 1'b0;
         verUncorr_q <= 1'b0;
      end else if (state_q == ST_VERIFY && verifyDone) begin
         verErr_q    <= verifyError || verifyUncorrectable;
         verUncorr_q <= verifyUncorrectable;
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         protReg_q <= `PROT_RESET_VALUE;
      end else if (state_q == ST_INIT && initProtValid) begin
         // a corrupt protection byte falls back to the fault pattern
         protReg_q <= initDoubleFault ? `PROT_FAULT_VALUE : initProtByte;
      end else if (wrHit(regAddr, `ADDR_EEPROM_PROT, regWr)) begin
         protReg_q <= regWrData;
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         ccIrqEn_q   <= 1'b0;
         dfIrqEn_q   <= 1'b0;
         sfIrqEn_q   <= 1'b0;
         paramIdx_q  <= 3'h0;
         launchIdx_q <= 3'h0;
      end else begin
         if (wrHit(regAddr, `ADDR_FLASH_CONFIG, regWr)) begin
            ccIrqEn_q <= regWrData[`BIT_CC_IRQ_EN];
         end
         if (wrHit(regAddr, `ADDR_ECC_CONFIG, regWr)) begin
            dfIrqEn_q <= regWrData[`BIT_DF_BIT];
            sfIrqEn_q <= regWrData[`BIT_SF_BIT];
         end
         if (wrHit(regAddr, `ADDR_PARAM_INDEX, regWr)) begin
            paramIdx_q <= regWrData[2:0];
         end
         if (launch) begin
            launchIdx_q <= paramIdx_q;
         end
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         dfFlag_q <= 1'b0;
         sfFlag_q <= 1'b0;
      end else begin
         if (eccDoubleFault) begin
            dfFlag_q <= 1'b1;
         end else if (wrHit(regAddr, `ADDR_ECC_STATUS, regWr) && regWrData[`BIT_DF_BIT]) begin
            dfFlag_q <= 1'b0;
         end
         if (eccSingleFault) begin
            sfFlag_q <= 1'b1;
         end else if (wrHit(regAddr, `ADDR_ECC_STATUS, regWr) && regWrData[`BIT_SF_BIT]) begin
            sfFlag_q <= 1'b0;
         end
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         eraseReq   <= 1'b0;
         eraseBlock <= 1'b0;
         eraseAddr  <= 18'h00000;
         verifyReq  <= 1'b0;
      end else begin
         if (state_q == ST_CHECK && !checkFail) begin
            eraseReq   <= 1'b1;
            eraseBlock <= isBlockErase;
            eraseAddr  <= isBlockErase ? `EE_BASE : cmdAddr;
         end else if (eraseDone) begin
            eraseReq <= 1'b0;
         end
         if (state_q == ST_ERASE && eraseDone) begin
            verifyReq <= 1'b1;
         end else if (verifyDone) begin
            verifyReq <= 1'b0;
         end
      end
   end

   always @* begin
      rdMux = 8'h00;
      case (regAddr)
         `ADDR_FLASH_CONFIG: rdMux = {ccIrqEn_q, 7'h00};
         `ADDR_FLASH_STATUS: rdMux = {ccFlag_q, 1'b0, access_error_flag_q, protViol_q, 2'h0,
                                      verErr_q, verUncorr_q};
         `ADDR_ECC_CONFIG:   rdMux = {6'h00, dfIrqEn_q, sfIrqEn_q};
         `ADDR_ECC_STATUS:   rdMux = {6'h00, dfFlag_q, sfFlag_q};
         `ADDR_EEPROM_PROT:  rdMux = protReg_q;
         `ADDR_PARAM_INDEX:  rdMux = {5'h00, paramIdx_q};
         default:            rdMux = 8'h00;
      endcase
   end

   // word data already sits in a flop, so only the lane choice and the other-register byte are registered here
   always @(posedge clk_sys) begin
      if (srst) begin
         rdOther_q <= 8'h00;
         rdSel_q   <= 2'h0;
      end else begin
         rdOther_q <= regRd ? rdMux : 8'h00;
         rdSel_q   <= !regRd ? 2'h0
                    : (regAddr == `ADDR_PARAM_HI) ? 2'h1
                    : (regAddr == `ADDR_PARAM_LO) ? 2'h2 : 2'h3;
      end
   end

   assign regRdData = (rdSel_q == 2'h1) ? memRdData[15:8]
                    : (rdSel_q == 2'h2) ? memRdData[7:0]
                    : (rdSel_q == 2'h3) ? rdOther_q : 8'h00;

   // levels follow flag and enable; the processor mask gates all three
   assign irqCmdComplete = ccFlag_q && ccIrqEn_q && !cpuIrqMask;
   assign irqDoubleFault = dfFlag_q && dfIrqEn_q && !cpuIrqMask;
   assign irqSingleFault = sfFlag_q && sfIrqEn_q && !cpuIrqMask;
endmodule
`default_nettype wire

//--- eeprom_command_protection_unit_assertions.sv
// assertions watching the ports of the eeprom command protection unit
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_cmd_regs.vh"
module eeprom_command_protection_unit_assertions (
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic [3:0]  regAddr,
   input wire logic [7:0]  regWrData,
   input wire logic        regWr,
   input wire logic [7:0]  initProtByte,
   input wire logic        initProtValid,
   input wire logic        initDoubleFault,
   input wire logic        eccDoubleFault,
   input wire logic        cpuIrqMask,
   input wire logic        eraseReq,
   input wire logic        eraseBlock,
   input wire logic [17:0] eraseAddr,
   input wire logic        eraseDone,
   input wire logic        verifyReq,
   input wire logic        irqCmdComplete,
   input wire logic        irqDoubleFault,
   input wire logic        irqSingleFault
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // shadows rebuilt from bus traffic, not read from the design
   logic [7:0]  prot_q;
   logic        pend_q;
   logic        dfEn_q;
   logic [17:0] limit;
   assign limit = 18'h0041F + {6'h0, prot_q[6:0], 5'h0};
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prot_q <= `PROT_RESET_VALUE;
         pend_q <= 1'b1;
         dfEn_q <= 1'b0;
      end else begin
         if (pend_q && initProtValid) begin
            prot_q <= initDoubleFault ? `PROT_FAULT_VALUE : initProtByte;
            pend_q <= 1'b0;
         end
         if (regWr && regAddr == `ADDR_EEPROM_PROT)
            prot_q <= regWrData;
         if (regWr && regAddr == `ADDR_ECC_CONFIG)
            dfEn_q <= regWrData[`BIT_DF_BIT];
      end
   end
   property p_irq_mask;
      cpuIrqMask |-> !(irqCmdComplete || irqDoubleFault || irqSingleFault);
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq seen while masked");
   property p_df_irq;
      !$past(srst) && $past(eccDoubleFault) && dfEn_q && !cpuIrqMask |-> irqDoubleFault;
   endproperty
   a_df_irq: assert property (p_df_irq) else $error("double fault irq missing");
   property p_erase_addr;
      $rose(eraseReq) && !eraseBlock |->
         eraseAddr >= `EE_BASE && eraseAddr <= `EE_END && !eraseAddr[0];
   endproperty
   a_erase_addr: assert property (p_erase_addr) else $error("bad erase address");
   property p_prot_range;
      $rose(eraseReq) && !eraseBlock && prot_q[7] |-> {eraseAddr[17:2], 2'b00} > limit;
   endproperty
   a_prot_range: assert property (p_prot_range) else $error("protected sector erased");
   property p_block_prot;
      $rose(eraseReq) && eraseBlock |-> !prot_q[7];
   endproperty
   a_block_prot: assert property (p_block_prot) else $error("block erase while protected");
   property p_launch;
      $rose(eraseReq) |-> $past(regWr, 2) && $past(regAddr, 2) == `ADDR_FLASH_STATUS
         && $past(regWrData[7], 2);
   endproperty
   a_launch: assert property (p_launch) else $error("erase without launch write");
   property p_erase_verify;
      eraseReq && eraseDone |=> !eraseReq && verifyReq;
   endproperty
   a_erase_verify: assert property (p_erase_verify) else $error("no verify after erase");
   property p_req_hold;
      eraseReq && !eraseDone |=> eraseReq;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("erase request dropped");
   property p_exclusive;
      !(eraseReq && verifyReq);
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("erase and verify overlap");
   property p_reset_quiet;
      $fell(srst) |-> !eraseReq && !verifyReq && !irqCmdComplete;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("activity after reset");
   c_verify: cover property ($rose(verifyReq));
   c_cc_irq: cover property ($rose(irqCmdComplete));
   c_df_irq: cover property (irqDoubleFault);
   c_block: cover property ($rose(eraseReq) && eraseBlock);
endmodule
bind eeprom_command_protection_unit eeprom_command_protection_unit_assertions
   i_eeprom_command_protection_unit_assertions (.clk_sys(clk_sys), .srst(srst),
   .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .initProtByte(initProtByte),
   .initProtValid(initProtValid), .initDoubleFault(initDoubleFault),
   .eccDoubleFault(eccDoubleFault), .cpuIrqMask(cpuIrqMask), .eraseReq(eraseReq),
   .eraseBlock(eraseBlock), .eraseAddr(eraseAddr), .eraseDone(eraseDone),
   .verifyReq(verifyReq), .irqCmdComplete(irqCmdComplete),
   .irqDoubleFault(irqDoubleFault), .irqSingleFault(irqSingleFault));
`default_nettype wire

//--- eeprom_command_protection_unit_test.sv
// self-checking testbench of the eeprom command protection unit
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_cmd_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("Error %0t: got %h expected %h", $time, g, e); end end
module eeprom_command_protection_unit_test;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic [3:0]  regAddr = 4'h0;
   logic [7:0]  regWrData = 8'h00;
   logic        regWr = 1'b0, regRd = 1'b0, initProtValid = 1'b0, initDoubleFault = 1'b0;
   logic [7:0]  regRdData, initProtByte = 8'h00, v;
   logic        cmdModeAllowed = 1'b1, eccSingleFault = 1'b0, eccDoubleFault = 1'b0;
   logic        cpuIrqMask = 1'b0, eraseDone = 1'b0, verifyDone = 1'b0, hold = 1'b0;
   logic        verifyError = 1'b0, verifyUncorrectable = 1'b0, lastBlock;
   logic        eraseReq, eraseBlock, verifyReq, irqCmdComplete, irqDoubleFault, irqSingleFault;
   logic [17:0] eraseAddr, lastAddr;
   int          fails = 0, total_checks = 0, cycles = 0, erases = 0;
   eeprom_command_protection_unit i_eeprom_command_protection_unit (.clk_sys(clk_sys),
      .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .initProtByte(initProtByte), .initProtValid(initProtValid),
      .initDoubleFault(initDoubleFault), .cmdModeAllowed(cmdModeAllowed),
      .eccSingleFault(eccSingleFault), .eccDoubleFault(eccDoubleFault),
      .cpuIrqMask(cpuIrqMask), .eraseReq(eraseReq), .eraseBlock(eraseBlock),
      .eraseAddr(eraseAddr), .eraseDone(eraseDone), .verifyReq(verifyReq),
      .verifyDone(verifyDone), .verifyError(verifyError),
      .verifyUncorrectable(verifyUncorrectable), .irqCmdComplete(irqCmdComplete),
      .irqDoubleFault(irqDoubleFault), .irqSingleFault(irqSingleFault));
   always #20 clk_sys = ~clk_sys;
   // array side answers next cycle; hold stalls it to keep a command running
   always @(posedge clk_sys) begin
      eraseDone <= eraseReq && !eraseDone && !hold;
      verifyDone <= verifyReq && !verifyDone && !hold;
      if (eraseReq) begin
         lastAddr <= eraseAddr;
         lastBlock <= eraseBlock;
      end
      // counted at completion, so an aborted erase never counts
      if (eraseReq && eraseDone)
         erases <= erases + 1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         final_report();
      end
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 v = regRdData;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      rd(a);
      `CHK(v, e)
   endtask
   task automatic settle;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic pw(input logic [2:0] i, input logic [7:0] h, input logic [7:0] l);
      wr(`ADDR_PARAM_INDEX, {5'h0, i});
      wr(`ADDR_PARAM_HI, h);
      wr(`ADDR_PARAM_LO, l);
   endtask
   task automatic launch(input logic [7:0] c, input logic [17:0] a, input logic [2:0] ix,
                         input logic m);
      pw(`IDX_CMD_WORD, c, {6'h0, a[17:16]});
      pw(`IDX_ADDR_WORD, a[15:8], a[7:0]);
      wr(`ADDR_PARAM_INDEX, {5'h0, ix});
      cmdModeAllowed <= m;
      wr(`ADDR_FLASH_STATUS, 8'h80);
   endtask
   task automatic waitcc;
      int n;
      n = 0;
      do begin
         settle();
         rd(`ADDR_FLASH_STATUS);
         n++;
      end while (!v[7] && n < 30);
   endtask
   // launch, let it finish, compare status and whether the array was asked to erase
   task automatic tryc(input logic [7:0] c, input logic [17:0] a, input logic [2:0] ix,
                       input logic m, input logic [7:0] es);
      int e0;
      e0 = erases;
      launch(c, a, ix, m);
      waitcc();
      `CHK(v, es)
      `CHK(erases - e0, (es[5:4] != 2'b00) ? 0 : 1)
      if (es[5:4] == 2'b00 && c == `CMD_SECTOR_ERASE)
         `CHK({lastBlock, lastAddr[17:2]}, {1'b0, a[17:2]})
      if (es[5:4] == 2'b00 && c == `CMD_BLOCK_ERASE)
         `CHK({lastBlock, lastAddr}, {1'b1, `EE_BASE})
      wr(`ADDR_FLASH_STATUS, 8'h30);
   endtask
   task automatic boot(input logic [7:0] b, input logic df);
      srst <= 1'b1;
      initProtByte <= b;
      initDoubleFault <= df;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      rchk(`ADDR_FLASH_STATUS, 8'h00);
      `CHK(eraseReq, 1'b0)
      @(posedge clk_sys);
      initProtValid <= 1'b1;
      @(posedge clk_sys);
      initProtValid <= 1'b0;
   endtask
   task automatic ecc(input logic dbl);
      @(posedge clk_sys);
      eccDoubleFault <= dbl;
      eccSingleFault <= !dbl;
      @(posedge clk_sys);
      eccDoubleFault <= 1'b0;
      eccSingleFault <= 1'b0;
   endtask
   initial begin
      boot(8'h85, 1'b1);
      rchk(`ADDR_EEPROM_PROT, 8'h7F);
      rchk(`ADDR_FLASH_STATUS, 8'h83);
      boot(8'h85, 1'b0);
      rchk(`ADDR_EEPROM_PROT, 8'h85);
      rchk(`ADDR_FLASH_STATUS, 8'h80);
      rchk(4'hF, 8'h00);
      $display("test init done");
      for (int i = 0; i < 8; i++)
         pw(i[2:0], 8'hA0 + i[7:0], 8'h50 + i[7:0]);
      for (int i = 0; i < 8; i++) begin
         wr(`ADDR_PARAM_INDEX, i[7:0]);
         rchk(`ADDR_PARAM_HI, (i < 6) ? 8'hA0 + i[7:0] : 8'h00);
         rchk(`ADDR_PARAM_LO, (i < 6) ? 8'h50 + i[7:0] : 8'h00);
      end
      $display("test param store done");
      tryc(8'h12, 18'h004BE, 3'h1, 1'b1, 8'h90);
      tryc(8'h12, 18'h004C0, 3'h1, 1'b1, 8'h80);
      tryc(8'h12, 18'h00500, 3'h0, 1'b1, 8'hA0);
      tryc(8'h12, 18'h00500, 3'h1, 1'b0, 8'hA0);
      tryc(8'h12, 18'h00501, 3'h1, 1'b1, 8'hA0);
      tryc(8'h12, 18'h003FE, 3'h1, 1'b1, 8'hA0);
      tryc(8'h12, 18'h01400, 3'h1, 1'b1, 8'hA0);
      tryc(8'h10, 18'h00000, 3'h0, 1'b1, 8'h90);
      verifyError <= 1'b1;
      tryc(8'h12, 18'h013FE, 3'h1, 1'b1, 8'h82);
      verifyUncorrectable <= 1'b1;
      tryc(8'h12, 18'h00600, 3'h1, 1'b1, 8'h83);
      verifyError <= 1'b0;
      verifyUncorrectable <= 1'b0;
      wr(`ADDR_EEPROM_PROT, 8'h05);
      tryc(8'h12, 18'h00400, 3'h1, 1'b1, 8'h80);
      tryc(8'h10, 18'h00000, 3'h0, 1'b1, 8'h80);
      wr(`ADDR_EEPROM_PROT, 8'hFF);
      rchk(`ADDR_EEPROM_PROT, 8'hFF);
      tryc(8'h12, 18'h013FE, 3'h1, 1'b1, 8'h90);
      $display("test launch checks done");
      hold <= 1'b1;
      wr(`ADDR_EEPROM_PROT, 8'h00);
      launch(8'h12, 18'h00500, 3'h1, 1'b1);
      wr(`ADDR_PARAM_HI, 8'hEE);
      rchk(`ADDR_PARAM_HI, 8'h05);
      rchk(`ADDR_FLASH_STATUS, 8'h00);
      hold <= 1'b0;
      waitcc();
      `CHK(v, 8'h80)
      wr(`ADDR_PARAM_HI, 8'h5A);
      rchk(`ADDR_PARAM_HI, 8'h5A);
      wr(`ADDR_FLASH_CONFIG, 8'h80);
      settle();
      `CHK(irqCmdComplete, 1'b1)
      cpuIrqMask <= 1'b1;
      settle();
      `CHK(irqCmdComplete, 1'b0)
      cpuIrqMask <= 1'b0;
      wr(`ADDR_FLASH_CONFIG, 8'h00);
      settle();
      `CHK(irqCmdComplete, 1'b0)
      $display("test lock and completion irq done");
      wr(`ADDR_ECC_CONFIG, 8'h03);
      ecc(1'b1);
      settle();
      `CHK({irqDoubleFault, irqSingleFault}, 2'b10)
      ecc(1'b0);
      rchk(`ADDR_ECC_STATUS, 8'h03);
      `CHK({irqDoubleFault, irqSingleFault}, 2'b11)
      wr(`ADDR_ECC_CONFIG, 8'h01);
      settle();
      `CHK({irqDoubleFault, irqSingleFault}, 2'b01)
      wr(`ADDR_ECC_STATUS, 8'h03);
      rchk(`ADDR_ECC_STATUS, 8'h00);
      `CHK(irqSingleFault, 1'b0)
      $display("test ecc irq done");
      hold <= 1'b1;
      launch(8'h12, 18'h00700, 3'h1, 1'b1);
      settle();
      `CHK(eraseReq, 1'b1)
      @(posedge clk_sys);
      boot(8'h00, 1'b0);
      hold <= 1'b0;
      rchk(`ADDR_FLASH_STATUS, 8'h80);
      `CHK(eraseReq, 1'b0)
      $display("test reset abort done");
      final_report();
   end
endmodule
`default_nettype wire
